// *** src/sbc_pkg.sv ***
// Package of constants for the sense block sample and calibration control
package sbc_pkg;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int CAL_TIME_US = 288;
  localparam int CAL_CYCLES = (CAL_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int GT_BASE_NS = 500;
  localparam int GT_BASE_CYCLES = GT_BASE_NS / CLK_PERIOD_NS;
  localparam int DT_STEP_NS = 100;
  localparam int DT_STEP_CYCLES = DT_STEP_NS / CLK_PERIOD_NS;
  localparam int NONOVERLAP_NS = 50;
  localparam int NONOVERLAP_CYCLES = NONOVERLAP_NS / CLK_PERIOD_NS;
  localparam int CAL_SWITCH_NS = 1000;
  localparam int CAL_SWITCH_CYCLES = CAL_SWITCH_NS / CLK_PERIOD_NS;
  // ****************************************************************
  // Field codes
  // ****************************************************************
  localparam logic [2:0] MUX_THIRD_10K = 3'h4;
  localparam logic [2:0] MUX_THIRD_DIRECT = 3'h7;
  localparam logic [1:0] THIRD_GAIN_BEMF = 2'h0;
  localparam logic [2:0] AUTO_PHASE_MASK = 3'h6;
  localparam logic [2:0] AUTO_PHASE_CODE = 3'h0;
  localparam logic [2:0] RST_AMP_CAL = 3'h7;
  // Calibration states
  typedef enum logic [3:0] {
    SBC_IDLE = 4'h1,
    SBC_CONNECT = 4'h2,
    SBC_ZERO = 4'h4,
    SBC_RELEASE = 4'h8
  } sbc_cal_state_t;
endpackage : sbc_pkg

// *** src/sbc_sense_ctrl.sv ***
// Sense block amplifier, sample-hold, calibration and dead-time control
`timescale 1ns/1ps
module sbc_sense_ctrl (
  input wire logic clk,
  input wire logic reset,
  input wire logic [2:0] high_side_input,
  input wire logic [2:0] low_side_input,
  input wire logic [2:0] high_side_on_flag,
  input wire logic [2:0] low_side_on_flag,
  input wire logic [2:0] gate_off,
  input wire logic sample_strobe_n,
  input wire logic adaptive_gap_disable,
  input wire logic pwm_input_mode,
  input wire logic [1:0] added_gap_time,
  input wire logic [1:0] transition_time_sel,
  input wire logic [2:0] amp_enable,
  input wire logic [5:0] amp_gain_sel,
  input wire logic [2:0] amp_sample_hold_en,
  input wire logic backemf_enable,
  input wire logic [1:0] backemf_gain_sel,
  input wire logic [2:0] floating_phase_sel,
  input wire logic [2:0] monitor_select,
  input wire logic [2:0] amp_cal_start,
  input wire logic third_amp_backemf_cal_start,
  input wire logic cal_to_shunt,
  input wire logic backemf_cal_connect,
  input wire logic [11:0] comparator_threshold,
  output logic [2:0] amp_active,
  output logic [11:0] amp_gain_onehot,
  output logic [2:0] amp_sample,
  output logic backemf_active,
  output logic [3:0] backemf_gain_onehot,
  output logic [2:0] sensed_phase,
  output logic backemf_sample,
  output logic third_to_monitor,
  output logic [2:0] comparator_active,
  output logic [2:0] input_switch_one,
  output logic [2:0] ground_switch_three,
  output logic [2:0] autozero,
  output logic backemf_autozero,
  output logic cal_busy,
  output logic [2:0] gap_cycles_high,
  output logic [2:0] gap_cycles_low,
  output logic [7:0] total_gap_cycles
);
  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Two-bit field to one-hot gain setting
  function automatic logic [3:0] sbc_onehot(input logic [1:0] code);
    sbc_onehot = 4'h1 << code;
  endfunction : sbc_onehot

  // ****************************************************************
  // Enables and gains
  // ****************************************************************
  genvar i;
  generate
    for (i = 0; i < 3; i++)
    begin : g_amp
      // Calibration forces the amplifier on so auto-zero can run
      assign amp_active[i] = amp_enable[i] | autozero[i];
      assign amp_gain_onehot[4*i+3:4*i] = sbc_onehot(amp_gain_sel[2*i+1:2*i]);
      assign comparator_active[i] = |comparator_threshold[4*i+3:4*i];
    end
  endgenerate

  // Back-EMF path, its gain only meaningful with third gain at 00b
  assign backemf_active = backemf_enable;
  assign backemf_gain_onehot = (amp_gain_sel[5:4] == sbc_pkg::THIRD_GAIN_BEMF)
    ? sbc_onehot(backemf_gain_sel) : 4'h0;
  assign third_to_monitor = !backemf_enable &&
    (monitor_select == sbc_pkg::MUX_THIRD_10K ||
     monitor_select == sbc_pkg::MUX_THIRD_DIRECT);

  // ****************************************************************
  // Current amplifier sample-hold
  // ****************************************************************
  // Enabled amplifiers share the strobe, the third only with back-EMF off, so the currents align
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      amp_sample <= 3'h0;
    else
    begin
      amp_sample[1:0] <= amp_sample_hold_en[1:0] & {2{!sample_strobe_n}};
      // Third switch kept open when back-EMF shares its capacitor
      amp_sample[2] <= amp_sample_hold_en[2] & !sample_strobe_n
        & !backemf_enable;
    end
  end

  // ****************************************************************
  // Floating phase selection
  // ****************************************************************
  logic strobe_q;
  logic [2:0] auto_phase;
  logic [2:0] float_bits;
  assign float_bits = ~(high_side_input | low_side_input);

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      strobe_q <= 1'b1;
    else
      strobe_q <= sample_strobe_n;
  end

  // Capture the undriven phase on a strobe falling edge when some phase is undriven, else hold it
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      auto_phase <= 3'h1;
    else if (strobe_q && !sample_strobe_n && float_bits != 3'h0)
      auto_phase <= float_bits[0] ? 3'h1 :
        (float_bits[1] ? 3'h2 : 3'h4);
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      sensed_phase <= 3'h1;
    else if (floating_phase_sel[2])
      sensed_phase <= (floating_phase_sel[1:0] == 2'h3) ? 3'h4 :
        3'(3'h1 << floating_phase_sel[1:0]);
    else
      sensed_phase <= auto_phase;
  end

  // ****************************************************************
  // Back-EMF sample switch timing
  // ****************************************************************
  logic [9:0] gt_count;
  logic gt_running;
  logic gt_done;
  logic [2:0] on_q;
  logic [2:0] off_q;
  logic [2:0] side_on;
  logic [9:0] gt_load;
  assign side_on = high_side_on_flag | low_side_on_flag;
  // 500 ns times 1,2,4,8
  assign gt_load = 10'(sbc_pkg::GT_BASE_CYCLES << transition_time_sel);

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      on_q <= 3'h0;
      off_q <= 3'h0;
    end
    else
    begin
      on_q <= side_on;
      off_q <= gate_off;
    end
  end

  // Delay starts when a side-on indication rises after an input edge
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      gt_count <= 10'h000;
      gt_running <= 1'b0;
      gt_done <= 1'b0;
    end
    else if ((side_on & ~on_q) != 3'h0)
    begin
      gt_count <= gt_load;
      gt_running <= 1'b1;
      gt_done <= 1'b0;
    end
    else if ((off_q & ~gate_off) != 3'h0)
    begin
      gt_running <= 1'b0;
      gt_done <= 1'b0;
    end
    else if (gt_running)
    begin
      gt_count <= gt_count - 10'h001;
      if (gt_count == 10'h001)
      begin
        gt_running <= 1'b0;
        gt_done <= 1'b1;
      end
    end
  end

  // Strobe and enable gate the switch; host may delay beyond gt_done
  assign backemf_sample = gt_done && backemf_enable
    && !sample_strobe_n && !cal_busy;

  // ****************************************************************
  // Offset calibration sequencer
  // ****************************************************************
  sbc_pkg::sbc_cal_state_t state;
  logic [2:0] pending;
  logic pending_bemf;
  logic [2:0] current;
  logic bemf_run;
  logic [15:0] cal_count;
  logic start_q;
  logic [2:0] cal_q;
  assign cal_busy = (state != sbc_pkg::SBC_IDLE);

  // Requests are latched; a rising start bit is never lost while busy
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pending <= sbc_pkg::RST_AMP_CAL;
      pending_bemf <= 1'b0;
      cal_q <= 3'h0;
      start_q <= 1'b0;
    end
    else
    begin
      cal_q <= amp_cal_start;
      start_q <= third_amp_backemf_cal_start;
      pending <= (pending & ~((state == sbc_pkg::SBC_IDLE &&
        !pending_bemf) ? (pending & -pending) : 3'h0))
        | (amp_cal_start & ~cal_q);
      pending_bemf <= (pending_bemf && state != sbc_pkg::SBC_IDLE)
        | (third_amp_backemf_cal_start & !start_q & backemf_enable);
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state <= sbc_pkg::SBC_IDLE;
      current <= 3'h0;
      bemf_run <= 1'b0;
      cal_count <= 16'h0000;
    end
    else
    begin
      unique case (state)
        sbc_pkg::SBC_IDLE:
        begin
          cal_count <= 16'(sbc_pkg::CAL_SWITCH_CYCLES);
          if (pending_bemf)
          begin
            bemf_run <= 1'b1;
            current <= 3'h0;
            state <= sbc_pkg::SBC_CONNECT;
          end
          else if (pending != 3'h0)
          begin
            bemf_run <= 1'b0;
            current <= pending & -pending;
            state <= sbc_pkg::SBC_CONNECT;
          end
        end
        sbc_pkg::SBC_CONNECT:
        begin
          cal_count <= cal_count - 16'h0001;
          if (cal_count == 16'h0001)
          begin
            cal_count <= 16'(sbc_pkg::CAL_CYCLES);
            state <= sbc_pkg::SBC_ZERO;
          end
        end
        sbc_pkg::SBC_ZERO:
        begin
          cal_count <= cal_count - 16'h0001;
          if (cal_count == 16'h0001)
            state <= sbc_pkg::SBC_RELEASE;
        end
        sbc_pkg::SBC_RELEASE:
        begin
          current <= 3'h0;
          bemf_run <= 1'b0;
          state <= sbc_pkg::SBC_IDLE;
        end
      endcase
    end
  end

  // Switch matrix: the calibrating input is grounded unless calibrating against the shunt
  always_comb
  begin
    input_switch_one = 3'h7;
    ground_switch_three = 3'h0;
    if (cal_busy && !bemf_run && !cal_to_shunt)
    begin
      input_switch_one = ~current;
      ground_switch_three = current;
    end
    // with cal_to_shunt set, switches one stay closed
  end

  // Auto-zero runs only after the inputs have settled
  assign autozero = (state == sbc_pkg::SBC_ZERO && !bemf_run)
    ? current : 3'h0;
  assign backemf_autozero = (state == sbc_pkg::SBC_ZERO) && bemf_run;

  // ****************************************************************
  // Dead-time composition
  // ****************************************************************
  logic [2:0] hi_q;
  logic [2:0] lo_q;
  logic [7:0] added;
  assign added = 8'(sbc_pkg::DT_STEP_CYCLES) << added_gap_time;

  // Flag each phase input falling edge with a one-cycle pulse
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      hi_q <= 3'h0;
      lo_q <= 3'h0;
      gap_cycles_high <= 3'h0;
      gap_cycles_low <= 3'h0;
    end
    else
    begin
      hi_q <= high_side_input;
      lo_q <= low_side_input;
      gap_cycles_high <= hi_q & ~high_side_input;
      gap_cycles_low <= lo_q & ~low_side_input;
    end
  end

  // Adaptive off: non-overlap plus added gap; PWM mode inserts the added gap only
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      total_gap_cycles <= 8'h00;
    else if (pwm_input_mode)
      total_gap_cycles <= added;
    else if (adaptive_gap_disable)
      total_gap_cycles <= added
        + 8'(sbc_pkg::NONOVERLAP_CYCLES);
    else
      total_gap_cycles <= added;
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  third_sh_open_a: assert property (@(posedge clk) disable iff (reset)
    backemf_enable |=> !amp_sample[2]) else $error("third switch closed");
  strobe_open_a: assert property (@(posedge clk) disable iff (reset)
    sample_strobe_n |-> !backemf_sample) else $error("bemf switch on");
  bemf_gate_a: assert property (@(posedge clk) disable iff (reset)
    backemf_sample |-> $past(gt_done) || gt_done) else $error("early");
  amp_sample_a: assert property (@(posedge clk) disable iff (reset)
    (amp_sample_hold_en[0] && !sample_strobe_n) |=> amp_sample[0])
    else $error("no sample");
  direct_phase_a: assert property (@(posedge clk) disable iff (reset)
    (floating_phase_sel == 3'h5) |=> sensed_phase == 3'h2)
    else $error("phase wrong");
  cal_len_a: assert property (@(posedge clk) disable iff (reset)
    $rose(state == sbc_pkg::SBC_ZERO) |-> ##1 (state == sbc_pkg::SBC_ZERO)[*8])
    else $error("cal short");
  pwm_gap_a: assert property (@(posedge clk) disable iff (reset)
    pwm_input_mode |=> total_gap_cycles == $past(added))
    else $error("pwm gap");
  cmp_off_a: assert property (@(posedge clk) disable iff (reset)
    comparator_threshold[3:0] == 4'h0 |-> !comparator_active[0])
    else $error("cmp on");
endmodule : sbc_sense_ctrl

// *** tb/sbc_host_model.sv ***
// Host model driving the bridge inputs, side-on flags and strobe
`timescale 1ns/1ps
module sbc_host_model (
  input wire logic clk,
  output logic [2:0] high_side_input,
  output logic [2:0] low_side_input,
  output logic [2:0] high_side_on_flag,
  output logic [2:0] low_side_on_flag,
  output logic [2:0] gate_off,
  output logic sample_strobe_n
);
  // Bridge idle and strobe high until told otherwise
  initial
  begin
    {high_side_input, low_side_input, gate_off} = 9'h000;
    {high_side_on_flag, low_side_on_flag} = 6'h00;
    sample_strobe_n = 1'b1;
  end

  // Switch sides on; the flags follow after a chosen lag (slow or prompt)
  task automatic commutate(input logic [2:0] hi, input logic [2:0] lo,
                           input int lag);
    @(posedge clk);
    high_side_input <= hi;
    low_side_input <= lo;
    repeat (lag) @(posedge clk);
    high_side_on_flag <= hi;
    low_side_on_flag <= lo;
  endtask : commutate

  // Drop a phase, then pulse its gate-off the way the driver does
  task automatic release_phase(input logic [2:0] mask);
    @(posedge clk);
    high_side_input <= high_side_input & ~mask;
    low_side_input <= low_side_input & ~mask;
    @(posedge clk);
    high_side_on_flag <= high_side_on_flag & ~mask;
    low_side_on_flag <= low_side_on_flag & ~mask;
    gate_off <= mask;
    repeat (2) @(posedge clk);
    gate_off <= 3'h0;
  endtask : release_phase

  // Strobe level change, launched just after an edge
  task automatic strobe(input logic level);
    @(posedge clk);
    sample_strobe_n <= level;
  endtask : strobe
endmodule : sbc_host_model

// *** tb/sbc_sense_ctrl_tb.sv ***
// Self-checking bench for the sense block control
`timescale 1ns/1ps
module sbc_sense_ctrl_tb;
  logic clk, reset, sample_strobe_n, adaptive_gap_disable, pwm_input_mode;
  logic [2:0] high_side_input, low_side_input, gate_off;
  logic [2:0] high_side_on_flag, low_side_on_flag, amp_cal_start;
  logic backemf_enable, cal_to_shunt, third_amp_backemf_cal_start;
  logic backemf_cal_connect, backemf_active, backemf_sample, cal_busy;
  logic third_to_monitor, backemf_autozero;
  logic [1:0] added_gap_time, transition_time_sel, backemf_gain_sel;
  logic [2:0] amp_enable, amp_sample_hold_en, floating_phase_sel;
  logic [2:0] monitor_select, amp_active, amp_sample, sensed_phase;
  logic [2:0] comparator_active, input_switch_one, ground_switch_three;
  logic [2:0] autozero, gap_cycles_high, gap_cycles_low;
  logic [5:0] amp_gain_sel;
  logic [11:0] comparator_threshold, amp_gain_onehot;
  logic [3:0] backemf_gain_onehot;
  logic [7:0] total_gap_cycles;
  logic [31:0] r;
  int fails, num_checks, n, run, first_run, hi_falls;

  sbc_sense_ctrl u_dut (.clk, .reset, .high_side_input, .low_side_input,
    .high_side_on_flag, .low_side_on_flag, .gate_off, .sample_strobe_n,
    .adaptive_gap_disable, .pwm_input_mode, .added_gap_time,
    .transition_time_sel, .amp_enable, .amp_gain_sel, .amp_sample_hold_en,
    .backemf_enable, .backemf_gain_sel, .floating_phase_sel,
    .monitor_select, .amp_cal_start, .third_amp_backemf_cal_start,
    .cal_to_shunt, .backemf_cal_connect, .comparator_threshold, .amp_active,
    .amp_gain_onehot, .amp_sample, .backemf_active, .backemf_gain_onehot,
    .sensed_phase, .backemf_sample, .third_to_monitor, .comparator_active,
    .input_switch_one, .ground_switch_three, .autozero, .backemf_autozero,
    .cal_busy, .gap_cycles_high, .gap_cycles_low, .total_gap_cycles);
  sbc_host_model u_host (.clk, .high_side_input, .low_side_input,
    .high_side_on_flag, .low_side_on_flag, .gate_off, .sample_strobe_n);

  // 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Length of the first calibration busy span
  always @(posedge clk)
  begin
    if (cal_busy === 1'b1) run <= run + 1;
    else if (run > 0 && first_run == 0) first_run <= run;
  end

  // Phase A high input falls, seen through the gap pulse output
  always @(posedge clk)
  begin
    if (gap_cycles_high[0] === 1'b1) hi_falls <= hi_falls + 1;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [11:0] exp_gain(input logic [5:0] g);
    logic [11:0] e;
    for (int i = 0; i < 3; i++) e[4*i +: 4] = 4'h1 << g[2*i +: 2];
    return e;
  endfunction : exp_gain

  function automatic logic [2:0] exp_cmp(input logic [11:0] t);
    logic [2:0] c;
    for (int i = 0; i < 3; i++) c[i] = (t[4*i +: 4] != 4'h0);
    return c;
  endfunction : exp_cmp

  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict

  // Watchdog; the run needs about 87000 cycles
  initial
  begin
    repeat (98000) @(posedge clk);
    fails++;
    give_verdict();
  end

  // Main sequence
  initial
  begin
    r = $urandom(96);
    {fails, num_checks, run, first_run, hi_falls} = '0;
    reset = 1'b1;
    {adaptive_gap_disable, pwm_input_mode, backemf_enable} = 3'h0;
    {cal_to_shunt, third_amp_backemf_cal_start, backemf_cal_connect} = 3'h0;
    {added_gap_time, transition_time_sel, backemf_gain_sel} = 6'h00;
    {amp_enable, floating_phase_sel, monitor_select, amp_cal_start} = 12'h000;
    amp_sample_hold_en = 3'h7;
    amp_gain_sel = 6'h00;
    comparator_threshold = 12'h000;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(negedge clk);
    check(cal_busy, 1'b1);
    // Random field sweep while amp1 is still connecting
    for (n = 0; n < 30; n++)
    begin
      @(posedge clk);
      r = $urandom;
      amp_enable <= r[2:0];
      amp_gain_sel <= r[8:3];
      backemf_gain_sel <= r[10:9];
      backemf_enable <= r[11];
      monitor_select <= (n < 2) ? 3'h4 + 3'(3 * n) : r[14:12];
      comparator_threshold <= r[26:15] & {{4{r[27]}}, {4{r[28]}}, {4{r[29]}}};
      @(negedge clk);
      check(amp_active, amp_enable);
      check(amp_gain_onehot, exp_gain(amp_gain_sel));
      check(backemf_active, backemf_enable);
      check(backemf_gain_onehot, (amp_gain_sel[5:4] ==
        sbc_pkg::THIRD_GAIN_BEMF) ? 4'h1 << backemf_gain_sel : 4'h0);
      check(third_to_monitor, ~backemf_enable &
        (monitor_select == sbc_pkg::MUX_THIRD_10K ||
         monitor_select == sbc_pkg::MUX_THIRD_DIRECT));
      check(comparator_active, exp_cmp(comparator_threshold));
    end
    backemf_enable <= 1'b0;
    for (n = 0; n < 200 && autozero[0] !== 1'b1; n++) @(posedge clk);
    @(negedge clk);
    check({input_switch_one[0], ground_switch_three[0]}, 2'h1);
    for (n = 0; n < 30000 && first_run == 0; n++) @(posedge clk);
    check(first_run, sbc_pkg::CAL_SWITCH_CYCLES + sbc_pkg::CAL_CYCLES + 1);
    for (n = 0; n < 300 && autozero[1] !== 1'b1; n++) @(posedge clk);
    cal_to_shunt <= 1'b1;
    repeat (2) @(negedge clk);
    check(input_switch_one[1], 1'b1);
    cal_to_shunt <= 1'b0;
    for (n = 0; n < 30000 && autozero[2] !== 1'b1; n++) @(posedge clk);
    for (n = 0; n < 30000 && cal_busy !== 1'b0; n++) @(posedge clk);
    // Back-EMF calibration request refused while disabled
    third_amp_backemf_cal_start <= 1'b1;
    repeat (3) @(negedge clk);
    check(cal_busy, 1'b0);
    third_amp_backemf_cal_start <= 1'b0;
    // Dead time with adaptive monitoring off, every added-gap code
    for (n = 0; n < 4; n++)
    begin
      @(posedge clk);
      adaptive_gap_disable <= 1'b1;
      added_gap_time <= n[1:0];
      u_host.commutate(3'h1, 3'h0, 1);
      u_host.release_phase(3'h1);
      repeat (3) @(negedge clk);
      check(total_gap_cycles, sbc_pkg::NONOVERLAP_CYCLES +
        (sbc_pkg::DT_STEP_CYCLES << n));
    end
    check(hi_falls, 4);
    // PWM mode inserts no input gap, only the added one
    @(posedge clk);
    pwm_input_mode <= 1'b1;
    repeat (2) @(negedge clk);
    check(total_gap_cycles, sbc_pkg::DT_STEP_CYCLES << 3);
    @(posedge clk);
    pwm_input_mode <= 1'b0;
    adaptive_gap_disable <= 1'b0;
    repeat (2) @(negedge clk);
    check(total_gap_cycles, sbc_pkg::DT_STEP_CYCLES << 3);
    // Back-EMF sample switch around a commutation, A high and B low
    backemf_enable <= 1'b1;
    u_host.commutate(3'h1, 3'h2, 3);
    u_host.strobe(1'b0);
    repeat (30) @(negedge clk);
    check(backemf_sample, 1'b0);
    check(sensed_phase, 3'h4);
    check(amp_sample, 3'h3);
    repeat (30) @(negedge clk);
    check(backemf_sample, 1'b1);
    backemf_enable <= 1'b0;
    repeat (2) @(negedge clk);
    check(backemf_sample, 1'b0);
    check(amp_sample, 3'h7);
    backemf_enable <= 1'b1;
    floating_phase_sel <= 3'h5;
    u_host.strobe(1'b1);
    repeat (2) @(negedge clk);
    check(backemf_sample, 1'b0);
    check(amp_sample, 3'h0);
    u_host.strobe(1'b0);
    repeat (3) @(negedge clk);
    check(backemf_sample, 1'b1);
    check(sensed_phase, 3'h2);
    u_host.release_phase(3'h1);
    repeat (2) @(negedge clk);
    check(backemf_sample, 1'b0);
    // Back-EMF auto-zero accepted once enabled
    third_amp_backemf_cal_start <= 1'b1;
    repeat (110) @(negedge clk);
    check({cal_busy, backemf_autozero}, 2'h3);
    give_verdict();
  end
endmodule : sbc_sense_ctrl_tb
